// file: rtl/sesp_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the port and rate divider files
`ifndef SESP_CFG_SVH
`define SESP_CFG_SVH

// ==========================================================
// register offsets
`define SESP_ADDR_DATA 2'h0
`define SESP_ADDR_CTRL 2'h1
`define SESP_ADDR_STAT 2'h2
`define SESP_ADDR_MASK 2'h3

// ==========================================================
// control field positions
`define SESP_CTRL_ENABLE 0
`define SESP_CTRL_RX_EN 1
`define SESP_CTRL_PHASE 2
`define SESP_CTRL_POLARITY 3
`define SESP_CTRL_RATE_LO 4
`define SESP_CTRL_RATE_HI 5

// ==========================================================
// status field positions
`define SESP_STAT_DONE 0
`define SESP_STAT_WR_FAULT 1
`define SESP_STAT_RD_FAULT 2
`define SESP_STAT_FULL 3
`define SESP_STAT_TX_BUSY 4
`define SESP_STAT_RX_BUSY 5

// ==========================================================
// reset values
`define SESP_CTRL_RESET 8'h00
`define SESP_DATA_RESET 8'h00
`define SESP_MASK_RESET 1'b0

// ==========================================================
// timing: fastest-rate base divisor of the oscillator clock
`define SESP_BASE_DIV 12
`define SESP_BASE_HALF (`SESP_BASE_DIV / 2)
`define SESP_LAST_HALF 4'hF

`endif

// file: rtl/sesp_pkg.sv
// types shared by the serial expansion shift port
// assumes: compiled before every module of the block
package sesp_pkg;

    // ==========================================================
    // transfer state
    typedef enum logic [1:0]
    {
        SESP_IDLE,
        SESP_TX,
        SESP_RX
    } sesp_state_e;

endpackage

// file: rtl/sesp_sync.sv
// two-flop synchroniser for one level from outside the mclk domain
// assumes: input is asynchronous to mclk
`timescale 1ns/1ps
module sesp_sync
#(
    parameter bit RESET_VAL = 1'b0
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// file: rtl/sesp_rate_div.sv
// half-bit enable divider for the shift rate
// assumes: run is high for the whole transfer, low otherwise
`timescale 1ns/1ps
`include "sesp_cfg.svh"
module sesp_rate_div
#(
    parameter int BASE_HALF = `SESP_BASE_HALF,
    parameter int CW = 9
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [1:0] rate_sel,
    // one-cycle enable every half bit
    output logic tick
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] limit;

    generate
        if (BASE_HALF < 1 || (BASE_HALF * 8) > (1 << CW))
        begin : g_bad
            $error("sesp_rate_div: BASE_HALF does not fit the counter");
        end
    endgenerate

    // half period is BASE_HALF doubled once per rate step
    assign limit = CW'((BASE_HALF << rate_sel) - 1);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else if (cnt == limit)
        begin
            cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// file: rtl/sesp_port.sv
// serial expansion shift port: byte register bus, clock and data pins
// assumes: mclk is the oscillator clock; the data pin input is
// asynchronous; the bus master never strobes read and write together
`timescale 1ns/1ps
`include "sesp_cfg.svh"
module sesp_port
import sesp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register bus
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // clock pin
    output logic xport_clock_pin,
    // data pin
    input wire logic xport_data_pin_in,
    output logic xport_data_pin_out,
    output logic xport_data_pin_oe,
    // interrupt
    output logic xport_irq
);
    // ==========================================================
    // state
    sesp_state_e state;
    logic [7:0] xport_shift_data;
    logic data_full;
    logic xport_enable;
    logic xport_rx_enable;
    logic clock_edge_phase;
    logic clock_idle_polarity;
    logic rate_select_hi;
    logic rate_select_lo;
    logic xport_done_flag;
    logic write_phase_fault;
    logic read_phase_fault;
    logic done_mask;
    logic [3:0] half_cnt;
    logic data_in;
    logic tick;
    localparam logic [7:0] CTRL_RST = `SESP_CTRL_RESET;

    // ==========================================================
    // decode
    logic busy;
    logic sel_data;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic guarded_access;
    logic data_wr_ok;
    logic data_rd_ok;
    logic ctrl_wr_ok;
    logic start_tx;
    logic start_rx;
    logic lead_edge;
    logic trail_edge;
    logic last_edge;
    logic sample_edge;
    logic change_edge;
    logic [2:0] bit_num;
    logic stat_clr;

    assign busy = (state != SESP_IDLE);
    assign sel_data = (reg_addr == `SESP_ADDR_DATA);
    assign sel_ctrl = (reg_addr == `SESP_ADDR_CTRL);
    assign sel_stat = (reg_addr == `SESP_ADDR_STAT);
    assign sel_mask = (reg_addr == `SESP_ADDR_MASK);
    assign guarded_access = (sel_data && (reg_wr || reg_rd)) || (sel_ctrl && reg_wr);
    assign data_wr_ok = reg_wr && sel_data && !busy;
    assign data_rd_ok = reg_rd && sel_data && !busy;
    assign ctrl_wr_ok = reg_wr && sel_ctrl && !busy;
    assign stat_clr = reg_wr && sel_stat;
    assign start_tx = data_wr_ok && xport_enable;
    // reception only when empty and idle
    assign start_rx = !busy && xport_enable && xport_rx_enable && !data_full
        && !data_wr_ok && !ctrl_wr_ok;

    assign lead_edge = tick && !half_cnt[0];
    assign trail_edge = tick && half_cnt[0];
    assign last_edge = trail_edge && (half_cnt == `SESP_LAST_HALF);
    assign bit_num = half_cnt[3:1];
    // phase picks which edges sample and which change
    assign sample_edge = clock_edge_phase ? trail_edge : lead_edge;
    assign change_edge = clock_edge_phase ? lead_edge : (trail_edge && !last_edge);

    // ==========================================================
    // data pin synchroniser and rate divider
    sesp_sync #(
        .RESET_VAL(1'b0)
    ) u_data_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in(xport_data_pin_in),
        .sync_out(data_in)
    );

    sesp_rate_div #(
        .BASE_HALF(`SESP_BASE_HALF),
        .CW(9)
    ) u_rate_div (
        .mclk(mclk),
        .rst(rst),
        .run(busy),
        .rate_sel({rate_select_hi, rate_select_lo}),
        .tick(tick)
    );

    // ==========================================================
    // control register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_enable <= CTRL_RST[`SESP_CTRL_ENABLE];
            clock_edge_phase <= CTRL_RST[`SESP_CTRL_PHASE];
            clock_idle_polarity <= CTRL_RST[`SESP_CTRL_POLARITY];
            rate_select_hi <= CTRL_RST[`SESP_CTRL_RATE_HI];
            rate_select_lo <= CTRL_RST[`SESP_CTRL_RATE_LO];
        end
        else if (ctrl_wr_ok)
        begin
            xport_enable <= reg_wdata[`SESP_CTRL_ENABLE];
            clock_edge_phase <= reg_wdata[`SESP_CTRL_PHASE];
            clock_idle_polarity <= reg_wdata[`SESP_CTRL_POLARITY];
            rate_select_hi <= reg_wdata[`SESP_CTRL_RATE_HI];
            rate_select_lo <= reg_wdata[`SESP_CTRL_RATE_LO];
        end
    end

    // receive enable: self-clearing
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_rx_enable <= 1'b0;
        end
        else if (state == SESP_RX && last_edge)
        begin
            xport_rx_enable <= 1'b0;
        end
        else if (ctrl_wr_ok)
        begin
            xport_rx_enable <= reg_wdata[`SESP_CTRL_RX_EN] && !data_full;
        end
    end

    // ==========================================================
    // transfer sequencer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= SESP_IDLE;
            half_cnt <= 4'h0;
        end
        else
        begin
            unique case (state)
                SESP_IDLE:
                begin
                    half_cnt <= 4'h0;
                    if (start_tx)
                    begin
                        state <= SESP_TX;
                    end
                    else if (start_rx)
                    begin
                        state <= SESP_RX;
                    end
                end
                SESP_TX, SESP_RX:
                begin
                    if (tick)
                    begin
                        half_cnt <= half_cnt + 4'h1;
                    end
                    if (last_edge)
                    begin
                        state <= SESP_IDLE;
                    end
                end
                default:
                begin
                    state <= SESP_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // shift data register and full flag
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_shift_data <= `SESP_DATA_RESET;
        end
        else if (data_wr_ok)
        begin
            xport_shift_data <= reg_wdata;
        end
        else if (state == SESP_RX && sample_edge)
        begin
            xport_shift_data <= {xport_shift_data[6:0], data_in};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            data_full <= 1'b0;
        end
        else if (data_wr_ok || (state == SESP_RX && last_edge))
        begin
            data_full <= 1'b1;
        end
        else if (data_rd_ok)
        begin
            data_full <= 1'b0;
        end
    end

    // ==========================================================
    // pins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_clock_pin <= 1'b0;
        end
        else if (!busy)
        begin
            xport_clock_pin <= clock_idle_polarity;
        end
        else if (tick)
        begin
            xport_clock_pin <= !xport_clock_pin;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_data_pin_out <= 1'b0;
            xport_data_pin_oe <= 1'b0;
        end
        else if (start_tx)
        begin
            // phase zero presents msb before first edge
            xport_data_pin_out <= clock_edge_phase ? 1'b0 : reg_wdata[7];
            xport_data_pin_oe <= !clock_edge_phase;
        end
        // data held one cycle past the last edge, the peer samples on it in phase one
        // release pin once idle
        else if (!busy)
        begin
            xport_data_pin_out <= 1'b0;
            xport_data_pin_oe <= 1'b0;
        end
        else if (state == SESP_TX && change_edge)
        begin
            xport_data_pin_oe <= 1'b1;
            if (clock_edge_phase)
            begin
                xport_data_pin_out <= xport_shift_data[3'd7 - bit_num];
            end
            else
            begin
                xport_data_pin_out <= xport_shift_data[3'd6 - bit_num];
            end
        end
    end

    // ==========================================================
    // status flags, set wins over clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_done_flag <= 1'b0;
        end
        else if (busy && last_edge)
        begin
            xport_done_flag <= 1'b1;
        end
        else if (stat_clr && reg_wdata[`SESP_STAT_DONE])
        begin
            xport_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            write_phase_fault <= 1'b0;
        end
        else if (guarded_access && state == SESP_TX)
        begin
            write_phase_fault <= 1'b1;
        end
        else if (stat_clr && reg_wdata[`SESP_STAT_WR_FAULT])
        begin
            write_phase_fault <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            read_phase_fault <= 1'b0;
        end
        else if (guarded_access && state == SESP_RX)
        begin
            read_phase_fault <= 1'b1;
        end
        else if (stat_clr && reg_wdata[`SESP_STAT_RD_FAULT])
        begin
            read_phase_fault <= 1'b0;
        end
    end

    // ==========================================================
    // interrupt mask and output
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            done_mask <= `SESP_MASK_RESET;
        end
        else if (reg_wr && sel_mask)
        begin
            done_mask <= reg_wdata[`SESP_STAT_DONE];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xport_irq <= 1'b0;
        end
        else
        begin
            xport_irq <= xport_done_flag && done_mask;
        end
    end

    // ==========================================================
    // read data, valid one cycle after the strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (!reg_rd)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            unique case (reg_addr)
                `SESP_ADDR_DATA:
                begin
                    reg_rdata <= data_rd_ok ? xport_shift_data : 8'h00;
                end
                `SESP_ADDR_CTRL:
                begin
                    reg_rdata <= {2'b00, rate_select_hi, rate_select_lo,
                        clock_idle_polarity, clock_edge_phase,
                        xport_rx_enable, xport_enable};
                end
                `SESP_ADDR_STAT:
                begin
                    reg_rdata <= {2'b00, state == SESP_RX, state == SESP_TX,
                        data_full, read_phase_fault, write_phase_fault,
                        xport_done_flag};
                end
                `SESP_ADDR_MASK:
                begin
                    reg_rdata <= {7'h00, done_mask};
                end
            endcase
        end
    end
endmodule

// file: testbench/sesp_port_asserts.sv
// checker for the shift port top: bus answers, pin idling, write fault flag
// assumes: bound to sesp_port; offsets and bit positions from sesp_cfg.svh
`timescale 1ns/1ps
`include "sesp_cfg.svh"
module sesp_port_asserts
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register bus
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and interrupt
    input wire logic xport_clock_pin,
    input wire logic xport_data_pin_in,
    input wire logic xport_data_pin_out,
    input wire logic xport_data_pin_oe,
    input wire logic xport_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // bus steps
    sequence s_data_acc_tx;
        (reg_wr || reg_rd) && reg_addr == `SESP_ADDR_DATA && xport_data_pin_oe;
    endsequence
    sequence s_stat_rd;
        reg_rd && reg_addr == `SESP_ADDR_STAT;
    endsequence

    // ==========================================================
    // assertions
    a_rdata_idle_zero:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside its answer cycle");
    a_fault_on_write:
    assert property (s_data_acc_tx ##[1:4] s_stat_rd |=> reg_rdata[`SESP_STAT_WR_FAULT])
        else $error("write fault missing after access during send");
    a_busy_shows_tx:
    assert property (s_stat_rd and xport_data_pin_oe |=> reg_rdata[`SESP_STAT_TX_BUSY])
        else $error("send busy bit low while data pin driven");
    a_busy_data_zero:
    assert property (reg_rd && reg_addr == `SESP_ADDR_DATA && xport_data_pin_oe
        |=> reg_rdata == 8'h00)
        else $error("refused data read returned a value");
    a_clock_half_bit:
    assert property ($changed(xport_clock_pin) |=> $stable(xport_clock_pin)[*5])
        else $error("clock pin edges closer than six cycles");
    a_out_released:
    assert property (!xport_data_pin_oe |-> !xport_data_pin_out)
        else $error("data out not zero while released");
    a_out_on_edge:
    assert property (xport_data_pin_oe && $past(xport_data_pin_oe)
        && $changed(xport_data_pin_out) |-> $changed(xport_clock_pin))
        else $error("data out moved away from a clock edge");
    a_irq_fall_write:
    assert property ($fell(xport_irq) |-> $past(reg_wr, 2)
        && ($past(reg_addr, 2) == `SESP_ADDR_STAT || $past(reg_addr, 2) == `SESP_ADDR_MASK))
        else $error("interrupt dropped without a status or mask write");
    a_mask_upper_zero:
    assert property ($past(reg_rd) && $past(reg_addr) == `SESP_ADDR_MASK
        |-> reg_rdata[7:1] == 7'h00)
        else $error("mask read shows bits above the done mask");
endmodule

bind sesp_port sesp_port_asserts chk_u
(
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xport_clock_pin(xport_clock_pin), .xport_data_pin_in(xport_data_pin_in),
    .xport_data_pin_out(xport_data_pin_out), .xport_data_pin_oe(xport_data_pin_oe),
    .xport_irq(xport_irq)
);

// file: testbench/sesp_peer.sv
// behavioural serial peripheral on the clock and data pins
// assumes: pol and pha match the device mode; byte reloads when peer_en rises
`timescale 1ns/1ps
module sesp_peer
(
    // clock pin and mode
    input wire logic sclk,
    input wire logic pol,
    input wire logic pha,
    // device side of the data pin
    input wire logic dut_out,
    input wire logic dut_oe,
    // byte to send and byte seen
    input wire logic peer_en,
    input wire logic [7:0] peer_byte,
    output logic pin,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic bitv = 1'b0;

    initial got = 8'h00;

    // released line shows the inverse of the last bit, never a kind value
    assign pin = dut_oe ? dut_out : (peer_en ? (pha ? bitv : sh[7]) : ~got[0]);

    // first bit starts wrong for phase one
    always @(posedge peer_en)
    begin
        sh = peer_byte;
        bitv = ~peer_byte[7];
    end

    always @(sclk)
    begin
        if ((sclk !== pol) ^ pha)
            got = {got[6:0], pin};
        else
        begin
            bitv = sh[7];
            sh = sh << 1;
        end
    end
endmodule

// file: testbench/sesp_port_tb.sv
// self-checking bench for the serial expansion shift port
// assumes: sesp_peer on the pins, checker bound to the top
`timescale 1ns/1ps
`include "sesp_cfg.svh"
module sesp_port_tb;
    localparam logic [1:0] DAT = `SESP_ADDR_DATA;
    localparam logic [1:0] CTL = `SESP_ADDR_CTRL;
    localparam logic [1:0] STA = `SESP_ADDR_STAT;
    localparam logic [1:0] MSK = `SESP_ADDR_MASK;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic clk_pin;
    logic pin;
    logic d_out;
    logic d_oe;
    logic irq;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic peer_en = 1'b0;
    logic [7:0] peer_byte = 8'h00;
    logic [7:0] got;
    logic prev_clk = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    int n_edges = 0;
    int cyc = 0;
    int t_last = 0;
    int t_prev = 0;

    always #25 mclk = ~mclk;

    sesp_port dut_u
    (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xport_clock_pin(clk_pin), .xport_data_pin_in(pin),
        .xport_data_pin_out(d_out), .xport_data_pin_oe(d_oe), .xport_irq(irq)
    );
    sesp_peer peer_u
    (
        .sclk(clk_pin), .pol(pol), .pha(pha), .dut_out(d_out), .dut_oe(d_oe),
        .peer_en(peer_en), .peer_byte(peer_byte), .pin(pin), .got(got)
    );

    // clock pin edges counted away from the launching edge
    always @(negedge mclk)
    begin
        cyc <= cyc + 1;
        prev_clk <= clk_pin;
        if (clk_pin !== prev_clk)
        begin
            n_edges <= n_edges + 1;
            t_prev <= t_last;
            t_last <= cyc;
        end
    end

    // ==========================================================
    // shared tasks
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge mclk);
        #1;
        chk({7'h00, irq}, {7'h00, e});
    endtask

    task automatic wait_irq();
        int i = 0;
        while (irq !== 1'b1 && i < 5000)
        begin
            @(posedge mclk);
            #1;
            i++;
        end
        if (irq !== 1'b1)
        begin
            n_fail++;
            stop_test();
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_tx(input logic [1:0] m, input logic [7:0] b);
        logic [7:0] c;
        int e0;
        c = {2'b00, m, m, 2'b01};
        pol <= m[1];
        pha <= m[0];
        wr(CTL, c & 8'hFE);
        wr(CTL, c);
        repeat (8) @(posedge mclk);
        #1;
        chk({7'h00, clk_pin}, {7'h00, m[1]});
        e0 = n_edges;
        wr(DAT, b);
        wait_irq();
        chk(8'(n_edges - e0), 8'd16);
        chk(8'(t_last - t_prev), 8'(6 << m));
        chk(got, b);
        chk({6'h00, clk_pin, d_oe}, {6'h00, m[1], 1'b0});
        rdc(STA, 8'h09);
        wr(MSK, 8'h00);
        irq_is(1'b0);
        wr(MSK, 8'h01);
        irq_is(1'b1);
        wr(STA, 8'h01);
        rdc(DAT, b);
        rdc(STA, 8'h00);
        irq_is(1'b0);
    endtask

    task automatic t_rx(input logic [1:0] m, input logic [7:0] b);
        logic [7:0] c;
        c = {2'b00, m, m, 2'b01};
        pol <= m[1];
        pha <= m[0];
        wr(CTL, c);
        peer_byte <= b;
        repeat (8) @(posedge mclk);
        peer_en <= 1'b1;
        wr(CTL, c | 8'h02);
        wait_irq();
        peer_en <= 1'b0;
        rdc(CTL, c);
        rdc(DAT, b);
        rdc(STA, 8'h01);
        wr(STA, 8'h01);
        irq_is(1'b0);
    endtask

    task automatic t_fault();
        pol <= 1'b0;
        pha <= 1'b0;
        wr(CTL, 8'h01);
        wr(DAT, 8'hC3);
        wr(DAT, 8'h3C);
        rdc(DAT, 8'h00);
        wr(CTL, 8'h3D);
        rdc(STA, 8'h1A);
        chk({7'h00, irq}, 8'h00);
        wait_irq();
        chk(got, 8'hC3);
        rdc(CTL, 8'h01);
        rdc(DAT, 8'hC3);
        wr(STA, 8'h03);
        rdc(STA, 8'h00);
        peer_byte <= 8'h5A;
        peer_en <= 1'b1;
        wr(CTL, 8'h03);
        rdc(DAT, 8'h00);
        rdc(STA, 8'h24);
        wait_irq();
        peer_en <= 1'b0;
        rdc(DAT, 8'h5A);
        rdc(STA, 8'h05);
        wr(STA, 8'h05);
        rdc(STA, 8'h00);
    endtask

    task automatic t_refuse();
        int e0;
        wr(CTL, 8'h00);
        repeat (8) @(posedge mclk);
        e0 = n_edges;
        wr(DAT, 8'h77);
        wr(CTL, 8'h01);
        wr(CTL, 8'h03);
        rdc(CTL, 8'h01);
        repeat (100) @(posedge mclk);
        chk(8'(n_edges - e0), 8'h00);
        rdc(STA, 8'h08);
        rdc(DAT, 8'h77);
    endtask

    task automatic t_reset_mid();
        pol <= 1'b1;
        wr(CTL, 8'h09);
        wr(DAT, 8'hF0);
        repeat (30) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        pol <= 1'b0;
        #1;
        chk({6'h00, clk_pin, d_oe}, 8'h00);
        rdc(CTL, 8'h00);
        rdc(STA, 8'h00);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rdc(CTL, 8'h00);
        rdc(STA, 8'h00);
        rdc(MSK, 8'h00);
        rdc(DAT, 8'h00);
        wr(MSK, 8'h01);
        for (int m = 0; m < 4; m++)
        begin
            t_tx(2'(m), 8'hA5 ^ 8'(m * 17));
        end
        for (int m = 0; m < 4; m++)
        begin
            t_rx(2'(m), 8'h3C ^ 8'(m * 65));
        end
        t_fault();
        t_refuse();
        t_reset_mid();
        stop_test();
    end
endmodule
